/* dcb_ctl.sv */
// Purpose: controller end: makes ck, issues commands, drives write bursts, takes read beats
// Assumes: user keeps mode settings sane; latency mirrored from issued mode commands
// Notes:   pins change together with ck edges so the device sees them aligned
//
// The implementer's own choices: the plain strobed port and the register offsets.
`default_nettype none
`include "dcb_map.svh"
module dcb_ctl
	import dcb_pkg::*;
(
	input  wire logic         sys_clk,   // system clock
	input  wire logic         rst,       // async reset, high
	dcb_if.ctl                lnk,       // link pins
	input  wire logic         cmd_valid, // command offered
	input  wire dcb_cmd_t     cmd_kind,  // command kind
	input  wire logic [2:0]   cmd_bank,  // bank address
	input  wire logic [12:0]  cmd_addr,  // row, column or mode bits
	input  wire logic [127:0] cmd_wdata, // write beats, beat 0 low
	output logic              cmd_ready, // command taken this cycle if offered
	output logic [15:0]       rd_data,   // read beat
	output logic              rd_valid   // read beat pulse
);
	localparam logic [2:0] CK_H = 3'(`DCB_CK_HALF);
	localparam logic [2:0] PF   = 3'(`DCB_CK_HALF - 1);
	localparam logic [2:0] PR   = 3'(2 * `DCB_CK_HALF - 1);

	dcb_ctl_st_t  r, n;
	logic         pr, pf, ok, take, go, last, isw;
	logic [3:0]   wl;
	logic [4:0]   half;
	logic [2:0]   b, s;
	logic [127:0] wbuf [0:7];

	always_comb begin
		n = r;
		ok = 1'h1;
		pr = r.cnt == PR;
		pf = r.cnt == PF;
		n.cnt = pr ? 3'h0 : r.cnt + 3'h1;
		n.ck = n.cnt < CK_H;
		wl = {1'h0, r.al} + {1'h0, r.cl} - 4'h1; // R10
		half = r.bl8 ? 5'h04 : 5'h02;
		isw = cmd_kind == DCB_WR;
		if (cmd_kind == DCB_RD || isw) begin
			if (isw == r.last_wr) begin
				ok = r.since_col == `DCB_TCCD || r.since_col >= half; // R5 R6 R21
			end else begin
				ok = r.since_col >= half + `DCB_TURN; // R5
			end
			if (r.al == 3'h0 && r.since_act < `DCB_TRCD) begin
				ok = 1'h0; // R9
			end
		end else if (cmd_kind == DCB_PRE) begin
			ok = r.since_wr >= {1'h0, wl} + half + `DCB_TWR; // R19
		end
		take = pf && ok && cmd_valid;
		if (pr) begin
			n.pipe = {dcb_went_t'('0), r.pipe[15:1]};
			n.since_col = (r.since_col == `DCB_SINCE_MAX) ? r.since_col : r.since_col + 5'h01;
			n.since_wr = (r.since_wr == `DCB_SINCE_MAX) ? r.since_wr : r.since_wr + 5'h01;
			n.since_act = (r.since_act == `DCB_SINCE_MAX) ? r.since_act : r.since_act + 5'h01;
		end
		if (pf) begin
			n.cs_n = 1'h0;
			{n.ras_n, n.cas_n, n.we_n} = `DCB_OP_NOP;
		end
		if (take) begin
			n.ba = cmd_bank;
			n.a = cmd_addr;
			case (cmd_kind)
				DCB_MRS: begin
					{n.ras_n, n.cas_n, n.we_n} = `DCB_OP_MRS;
					if (cmd_bank == `DCB_BA_MR) begin
						n.bl8 = cmd_addr[2:0] == `DCB_MR_BL8;
						n.cl = cmd_addr[`DCB_MR_CL_LSB +: 3];
					end else if (cmd_bank == `DCB_BA_EMR1) begin
						n.al = cmd_addr[`DCB_EMR_AL_LSB +: 3];
					end
				end
				DCB_ACT: begin
					{n.ras_n, n.cas_n, n.we_n} = `DCB_OP_ACT;
					n.since_act = 5'h00;
				end
				DCB_RD: begin
					{n.ras_n, n.cas_n, n.we_n} = `DCB_OP_RD;
					n.since_col = 5'h00;
					n.last_wr = 1'h0;
				end
				DCB_WR: begin
					{n.ras_n, n.cas_n, n.we_n} = `DCB_OP_WR;
					n.since_col = 5'h00;
					n.since_wr = 5'h00;
					n.last_wr = 1'h1;
					n.pipe[wl] = '{v: 1'h1, slot: r.wp}; // R10
					n.wp = r.wp + 3'h1;
				end
				DCB_PRE: {n.ras_n, n.cas_n, n.we_n} = `DCB_OP_PRE;
				DCB_REF: {n.ras_n, n.cas_n, n.we_n} = `DCB_OP_REF;
				default: {n.ras_n, n.cas_n, n.we_n} = `DCB_OP_NOP;
			endcase
		end
		// write burst: beat 0 on the rising ck edge write latency after the command
		if (pr && r.pipe[0].v) begin
			n.wact = 1'h1;
			n.wslot = r.pipe[0].slot;
		end
		go = (pr && r.pipe[0].v) || ((pr || pf) && r.wact);
		b = (pr && r.pipe[0].v) ? 3'h0 : r.wbeat;
		s = n.wslot;
		last = b == (r.bl8 ? 3'h7 : 3'h3);
		if (go) begin
			n.wdq = wbuf[s][{b, 4'h0} +: 16]; // R17
			n.wdq_oe = 1'h1;
			n.wdqs = pr;
			n.wdqs_oe = 1'h1;
			n.wbeat = b + 3'h1;
			n.wact = !last;
		end else if (pf && r.pipe[0].v) begin
			n.wdqs = 1'h0; // R17
			n.wdqs_oe = 1'h1;
		end else if (pr) begin
			n.wdqs = 1'h0;
			n.wdqs_oe = 1'h0;
			n.wdq_oe = 1'h0;
		end
		// read beats: every strobe edge not of our own making is one beat
		n.d1 = {lnk.dqs, lnk.dq};
		n.d2 = r.d1;
		n.d3 = r.d2;
		n.hist = {r.hist[2:0], r.wdqs_oe};
		n.rd_valid = 1'h0;
		if (r.d2[16] == r.d3[16]) begin
			n.dqsf = r.d3[16];
			if (r.d3[16] != r.dqsf && r.hist == 4'h0 && !r.wdqs_oe) begin
				n.rd_valid = 1'h1;
				n.rd_data = r.d3[15:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.cs_n <= 1'h1;
			r.cl <= `DCB_CL_RST;
			r.since_col <= `DCB_SINCE_MAX;
			r.since_wr <= `DCB_SINCE_MAX;
			r.since_act <= `DCB_SINCE_MAX;
		end else begin
			r <= n;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (take && isw) begin
			wbuf[r.wp] <= cmd_wdata;
		end
	end

	assign cmd_ready      = pf && ok;
	assign rd_data        = r.rd_data;
	assign rd_valid       = r.rd_valid;
	assign lnk.ck         = r.ck;
	assign lnk.cs_n       = r.cs_n;
	assign lnk.ras_n      = r.ras_n;
	assign lnk.cas_n      = r.cas_n;
	assign lnk.we_n       = r.we_n;
	assign lnk.ba         = r.ba;
	assign lnk.a          = r.a;
	assign lnk.dq_ctl     = r.wdq;
	assign lnk.dq_ctl_en  = r.wdq_oe;
	assign lnk.dqs_ctl    = r.wdqs;
	assign lnk.dqs_ctl_en = r.wdqs_oe;
endmodule : dcb_ctl
`default_nettype wire

/* dcb_dram.sv */
// Purpose: memory device end: command decode, posted column commands, burst engine
// Assumes: link pins and ck sampled on sys_clk; one page of each bank held
// Notes:   data beats follow ck edges; write data sampled only at the ck edges of a write burst
// Contract
// R1 - NOP command changes no internal state
// R2 - deselect ignores all command and address pins
// R3 - page split into 4- or 8-column segments
// R4 - burst starts at given column, wraps in segment
// R5 - controller never interrupts BL4; BL8 same-type only
// R6 - controller spaces column commands at least tCCD
// R7 - column command held AL clocks before execution
// R8 - read latency is AL plus CL
// R9 - early column commands need nonzero AL
// R10 - write latency is AL plus CL minus one
// R11 - only BL4/BL8; type from mode bit three
// R12 - sequential order counts up within nibble
// R13 - interleaved order is start XOR beat count
// R14 - no burst stop command exists
// R15 - read preamble low one clock, data on DQS
// R16 - CL from mode register, AL from extended
// R17 - controller drives write preamble and write beats
// R18 - capture exactly BL write beats, ignore rest
// R19 - controller waits write recovery before precharge
// R20 - back-to-back bursts at tCCD are seamless
// R21 - interruption exactly two clocks after previous
// R22 - auto-precharge only when A10 high
// R23 - NOP or deselect does not stop bursts
// R24 - release strobe after half-clock postamble
`default_nettype none
`include "dcb_map.svh"
module dcb_dram
	import dcb_pkg::*;
(
	input  wire logic       sys_clk,  // system clock
	input  wire logic       rst,      // async reset, high
	dcb_if.dev              lnk,      // link pins
	output logic            mode_bl8, // burst length 8 selected
	output logic            mode_ilv, // interleaved order selected
	output logic [2:0]      mode_cl,  // CAS latency
	output logic [2:0]      mode_al,  // additive latency
	output logic            arr_valid, // one array beat
	output logic            arr_we,   // beat is a write
	output logic [2:0]      arr_bank, // beat bank
	output logic [9:0]      arr_col,  // beat column
	output logic            ap_fire,  // auto-precharge starts
	output logic [2:0]      ap_bank   // bank being precharged
);
	dcb_dev_st_t r, n;
	dcb_ent_t    e;
	logic        rise, fall, start, go, last, mem_we;
	logic [3:0]  lat;
	logic [2:0]  b;
	logic [9:0]  c;
	logic [12:0] mem_addr;
	logic [15:0] rd_word;
	logic [15:0] mem [0:8191];

	// only the three low column bits move; segment bits stay put
	function automatic logic [9:0] burst_col(input logic [9:0] col, input logic [2:0] beat,
		input logic bl8, input logic ilv);
		logic [2:0] o;
		o = col[2:0];
		if (ilv) begin
			o = col[2:0] ^ {bl8 & beat[2], beat[1:0]}; // R13
		end else begin
			o = {col[2] ^ (bl8 & beat[2]), col[1:0] + beat[1:0]}; // R12
		end
		return {col[9:3], o}; // R3 R4
	endfunction : burst_col

	always_comb begin
		n = r;
		e = '0;
		mem_we = 1'h0;
		n.p1 = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n, lnk.ba, lnk.a, lnk.dq};
		n.p2 = r.p1;
		n.p3 = r.p2;
		n.ck = {r.ck[1:0], lnk.ck};
		if (r.ck[1] == r.ck[2]) begin
			n.ckf = r.ck[2];
		end
		rise = (r.ck[1] == r.ck[2]) && r.ck[2] && !r.ckf;
		fall = (r.ck[1] == r.ck[2]) && !r.ck[2] && r.ckf;
		n.arr_v = 1'h0;
		n.ap_fire = 1'h0;
		lat = {1'h0, r.al} + {1'h0, r.cl}; // R8
		start = rise && r.pipe[0].v;
		if (rise) begin
			n.pipe = {dcb_ent_t'('0), r.pipe[15:1]};
			if (!r.p3.cs_n) begin // R2
				case ({r.p3.ras_n, r.p3.cas_n, r.p3.we_n})
					`DCB_OP_MRS: begin
						if (r.p3.ba == `DCB_BA_MR) begin // R16
							if (r.p3.a[2:0] == `DCB_MR_BL4) begin // R11
								n.bl8 = 1'h0;
							end else if (r.p3.a[2:0] == `DCB_MR_BL8) begin // R11
								n.bl8 = 1'h1;
							end
							n.ilv = r.p3.a[`DCB_MR_BT]; // R11
							n.cl = r.p3.a[`DCB_MR_CL_LSB +: 3];
						end else if (r.p3.ba == `DCB_BA_EMR1) begin
							n.al = r.p3.a[`DCB_EMR_AL_LSB +: 3]; // R16
						end
					end
					`DCB_OP_RD, `DCB_OP_WR: begin
						e.v = 1'h1;
						e.wr = !r.p3.we_n;
						e.ap = r.p3.a[`DCB_AP_BIT]; // R22
						e.bank = r.p3.ba;
						e.col = r.p3.a[9:0]; // R4
						if (!r.p3.we_n) begin
							lat = lat - 4'h1; // R10
						end
						// accepted at any time after activate, executed lat clocks later
						n.pipe[lat - 4'h1] = e; // R7
					end
					default: begin
						// no-op, and commands this engine does not own
					end // R1
				endcase
			end
		end
		// a new start overrides a running burst: seamless or interrupted
		if (start) begin // R20
			n.act = 1'h1;
			n.bwr = r.pipe[0].wr;
			n.bap = r.pipe[0].ap;
			n.bbank = r.pipe[0].bank;
			n.bcol = r.pipe[0].col;
		end
		b = start ? 3'h0 : r.beat;
		go = start || ((rise || fall) && r.act); // R23
		c = burst_col(n.bcol, b, r.bl8, r.ilv);
		mem_addr = {n.bbank, c};
		rd_word = mem[mem_addr];
		last = b == (r.bl8 ? 3'h7 : 3'h3);
		if (go) begin
			n.beat = b + 3'h1;
			n.act = !last; // R14
			n.arr_v = 1'h1;
			n.arr_we = n.bwr;
			n.arr_bank = n.bbank;
			n.arr_col = c;
			if (last && n.bap) begin
				n.ap_fire = 1'h1; // R22
				n.ap_bank = n.bbank;
			end
			if (n.bwr) begin
				mem_we = 1'h1; // R18
				n.dq_oe = 1'h0;
				n.dqs_oe = 1'h0;
			end else begin
				n.dq = rd_word;
				n.dq_oe = 1'h1;
				n.dqs_oe = 1'h1;
				n.dqs = rise; // R15
			end
		end else if (rise) begin
			// low strobe one clock ahead of a read; otherwise release after postamble
			n.dq_oe = 1'h0;
			n.dqs = 1'h0;
			n.dqs_oe = n.pipe[0].v && !n.pipe[0].wr; // R15 R24
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.cl <= `DCB_CL_RST;
		end else begin
			r <= n;
		end
	end

	// array has no reset; late data past the burst never reaches it
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[mem_addr] <= r.p3.dq; // R18
		end
	end

	assign lnk.dq_dev     = r.dq;
	assign lnk.dq_dev_en  = r.dq_oe;
	assign lnk.dqs_dev    = r.dqs;
	assign lnk.dqs_dev_en = r.dqs_oe;
	assign mode_bl8       = r.bl8;
	assign mode_ilv       = r.ilv;
	assign mode_cl        = r.cl;
	assign mode_al        = r.al;
	assign arr_valid      = r.arr_v;
	assign arr_we         = r.arr_we;
	assign arr_bank       = r.arr_bank;
	assign arr_col        = r.arr_col;
	assign ap_fire        = r.ap_fire;
	assign ap_bank        = r.ap_bank;
endmodule : dcb_dram
`default_nettype wire

/* dcb_if.sv */
// Purpose: link between controller and memory device, shared pins resolved here
// Assumes: at most one end enables a shared pin at a time
// Notes:   an undriven strobe or data pin reads low
`default_nettype none
interface dcb_if;
	logic        ck;
	logic        cs_n, ras_n, cas_n, we_n;
	logic [2:0]  ba;
	logic [12:0] a;
	logic [15:0] dq_dev, dq_ctl, dq;
	logic        dq_dev_en, dq_ctl_en;
	logic        dqs_dev, dqs_dev_en, dqs_ctl, dqs_ctl_en, dqs;
	assign dq  = dq_dev_en ? dq_dev : (dq_ctl_en ? dq_ctl : 16'h0000);
	assign dqs = dqs_dev_en ? dqs_dev : (dqs_ctl_en ? dqs_ctl : 1'h0);
	modport dev (input ck, cs_n, ras_n, cas_n, we_n, ba, a, dq, dqs,
		output dq_dev, dq_dev_en, dqs_dev, dqs_dev_en);
	modport ctl (output ck, cs_n, ras_n, cas_n, we_n, ba, a, dq_ctl, dq_ctl_en, dqs_ctl,
		dqs_ctl_en, input dq, dqs);
endinterface : dcb_if
`default_nettype wire

/* dcb_map.svh */
// Purpose: pin encodings, mode fields and timing counts of the column burst link
// Assumes: sys_clk at 100 MHz, link clock made by the controller by division
// Notes:   definitions only
`ifndef DCB_MAP_SVH
`define DCB_MAP_SVH
`define DCB_SYS_NS     10
`define DCB_CK_NS      80
`define DCB_CK_HALF    (`DCB_CK_NS / `DCB_SYS_NS / 2)
`define DCB_OP_NOP     3'h7
`define DCB_OP_MRS     3'h0
`define DCB_OP_REF     3'h1
`define DCB_OP_PRE     3'h2
`define DCB_OP_ACT     3'h3
`define DCB_OP_WR      3'h4
`define DCB_OP_RD      3'h5
`define DCB_MR_BL4     3'h2
`define DCB_MR_BL8     3'h3
`define DCB_MR_BT      3
`define DCB_MR_CL_LSB  4
`define DCB_EMR_AL_LSB 3
`define DCB_AP_BIT     10
`define DCB_BA_MR      3'h0
`define DCB_BA_EMR1    3'h1
`define DCB_CL_RST     3'h3
`define DCB_TCCD       5'h02
`define DCB_TRCD       5'h03
`define DCB_TWR        5'h03
`define DCB_TURN       5'h02
`define DCB_SINCE_MAX  5'h1F
`endif

/* dcb_pkg.sv */
// Purpose: types shared by both ends of the column burst link
// Assumes: nothing
// Notes:   state structs hold every flip-flop of each end except the controller's write buffer and the device's array
`default_nettype none
package dcb_pkg;
	typedef enum logic [2:0] {DCB_NOP, DCB_MRS, DCB_ACT, DCB_RD, DCB_WR, DCB_PRE, DCB_REF} dcb_cmd_t;
	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [2:0]  ba;
		logic [12:0] a;
		logic [15:0] dq;
	} dcb_pin_t;
	typedef struct packed {
		logic       v;
		logic       wr;
		logic       ap;
		logic [2:0] bank;
		logic [9:0] col;
	} dcb_ent_t;
	typedef struct packed {
		logic       v;
		logic [2:0] slot;
	} dcb_went_t;
	typedef struct packed {
		dcb_pin_t        p1, p2, p3;
		logic [2:0]      ck;
		logic            ckf;
		logic            bl8, ilv;
		logic [2:0]      cl, al;
		dcb_ent_t [15:0] pipe;
		logic            act, bwr, bap;
		logic [2:0]      beat, bbank;
		logic [9:0]      bcol;
		logic [15:0]     dq;
		logic            dq_oe, dqs, dqs_oe;
		logic            arr_v, arr_we;
		logic [2:0]      arr_bank;
		logic [9:0]      arr_col;
		logic            ap_fire;
		logic [2:0]      ap_bank;
	} dcb_dev_st_t;
	typedef struct packed {
		logic [2:0]       cnt;
		logic             ck, cs_n, ras_n, cas_n, we_n;
		logic [2:0]       ba;
		logic [12:0]      a;
		logic             bl8, last_wr;
		logic [2:0]       cl, al;
		logic [4:0]       since_col, since_wr, since_act;
		dcb_went_t [15:0] pipe;
		logic [2:0]       wp;
		logic             wact;
		logic [2:0]       wbeat, wslot;
		logic [15:0]      wdq;
		logic             wdq_oe, wdqs, wdqs_oe;
		logic [16:0]      d1, d2, d3;
		logic             dqsf;
		logic [3:0]       hist;
		logic [15:0]      rd_data;
		logic             rd_valid;
	} dcb_ctl_st_t;
endpackage : dcb_pkg
`default_nettype wire

/* dcb_properties.sv */
// Purpose: link checks between the controller and memory device ends
// Assumes: one clock domain, sys_clk, with rst asynchronous and high
// Notes:   watches command pins and each end's own strobe and enables before the interface resolves them
`default_nettype none
module dcb_properties (
	input wire logic sys_clk,    // system clock
	input wire logic rst,        // async reset, high
	input wire logic cs_n,       // chip select
	input wire logic ras_n,      // row strobe
	input wire logic cas_n,      // column strobe
	input wire logic dq_dev_en,  // device drives data
	input wire logic dqs_dev,    // device strobe
	input wire logic dqs_dev_en, // device drives strobe
	input wire logic dq_ctl_en,  // controller drives data
	input wire logic dqs_ctl,    // controller strobe
	input wire logic dqs_ctl_en  // controller drives strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       col;
	logic       col_q;
	logic [5:0] gap;
	logic [7:0] run;
	assign col = !cs_n && ras_n && !cas_n;
	// gap saturates so a long idle span never wraps into a false short gap
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			col_q <= 1'b0;
			gap   <= 6'h3F;
			run   <= 8'h00;
		end else begin
			col_q <= col;
			gap   <= (col && !col_q) ? 6'h00 : ((gap == 6'h3F) ? gap : gap + 6'h01);
			run   <= dq_ctl_en ? run + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_bus_excl; !(dq_dev_en && dq_ctl_en) && !(dqs_dev_en && dqs_ctl_en); endproperty
	a_bus_excl: assert property (p_bus_excl) else $error("both ends drive the bus");
	property p_rd_pre; $rose(dqs_dev_en) |-> !dqs_dev [*7]; endproperty
	a_rd_pre: assert property (p_rd_pre) else $error("read preamble too short");
	property p_rd_first; $rose(dq_dev_en) |-> dqs_dev && dqs_dev_en; endproperty
	a_rd_first: assert property (p_rd_first) else $error("first read beat off strobe rise");
	property p_dq_strobe; dq_dev_en |-> dqs_dev_en; endproperty
	a_dq_strobe: assert property (p_dq_strobe) else $error("read data without strobe");
	property p_rd_post; $fell(dqs_dev_en) |-> !$past(dqs_dev); endproperty
	a_rd_post: assert property (p_rd_post) else $error("no low postamble");
	property p_wr_pre;
		$rose(dqs_ctl_en) |-> (!dqs_ctl && !dq_ctl_en) [*4] ##1 (dqs_ctl && dq_ctl_en);
	endproperty
	a_wr_pre: assert property (p_wr_pre) else $error("write preamble wrong");
	property p_wr_run; $fell(dq_ctl_en) |-> run[2:0] == 3'h0 && run >= 8'h10; endproperty
	a_wr_run: assert property (p_wr_run) else $error("write beats not whole");
	property p_ccd; col && !col_q |-> gap >= 6'h0F; endproperty
	a_ccd: assert property (p_ccd) else $error("column commands too close");
endmodule : dcb_properties
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench joining the controller and memory device ends
// Assumes: sys_clk at 100 MHz; the controller makes the link clock
// Notes:   latencies are judged as differences, so the device's sync delay cancels
`default_nettype none
module testbench
	import dcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic         sys_clk, rst, cmd_valid, cmd_ready, rd_valid, arr_valid, ap_fire;
	logic         mode_bl8, mode_ilv, arr_we;
	dcb_cmd_t     cmd_kind;
	logic [2:0]   cmd_bank, mode_cl, mode_al, ap_bank, arr_bank;
	logic [12:0]  cmd_addr;
	logic [127:0] wd;
	logic [15:0]  rd_data;
	logic [9:0]   arr_col;
	logic [9:0]   cols[$];
	logic [15:0]  rdq[$];
	logic [2:0]   aps[$];
	logic [3:0]   abk[$];
	int           rdt[$];
	int           cyc = 0;
	int           errors = 0;
	int           n_tests = 0;
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	dcb_if lnk ();
	dcb_ctl i_dcb_ctl (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_wdata(wd),
		.cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid));
	dcb_dram i_dcb_dram (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .mode_bl8(mode_bl8),
		.mode_ilv(mode_ilv), .mode_cl(mode_cl), .mode_al(mode_al), .arr_valid(arr_valid),
		.arr_we(arr_we), .arr_bank(arr_bank), .arr_col(arr_col), .ap_fire(ap_fire),
		.ap_bank(ap_bank));
	dcb_properties i_dcb_properties (.sys_clk(sys_clk), .rst(rst), .cs_n(lnk.cs_n),
		.ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .dq_dev_en(lnk.dq_dev_en),
		.dqs_dev(lnk.dqs_dev), .dqs_dev_en(lnk.dqs_dev_en), .dq_ctl_en(lnk.dq_ctl_en),
		.dqs_ctl(lnk.dqs_ctl), .dqs_ctl_en(lnk.dqs_ctl_en));
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (arr_valid === 1'b1) cols.push_back(arr_col);
		if (arr_valid === 1'b1) abk.push_back({arr_we, arr_bank});
		if (rd_valid === 1'b1) begin
			rdq.push_back(rd_data);
			rdt.push_back(cyc);
		end
		if (ap_fire === 1'b1) aps.push_back(ap_bank);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// leaves the request up so a following command can be queued with no gap
	task automatic issue(input dcb_cmd_t k, input logic [2:0] b, input logic [12:0] ad);
		int n;
		cmd_valid <= 1'b1;
		cmd_kind  <= k;
		cmd_bank  <= b;
		cmd_addr  <= ad;
		for (n = 0; n < 200; n++) begin
			@(negedge sys_clk);
			if (cmd_ready === 1'b1) break;
		end
		// a command never taken is a hang, not a pass
		if (n == 200) errors++;
		@(posedge sys_clk);
	endtask : issue
	task automatic pause;
		cmd_valid <= 1'b0;
		repeat (160) @(posedge sys_clk);
	endtask : pause
	task automatic setm(input logic b8, input logic il, input logic [2:0] cl, input logic [2:0] al);
		issue(DCB_MRS, 3'h0, {6'h00, cl, il, 2'h1, b8});
		issue(DCB_MRS, 3'h1, {7'h00, al, 3'h0});
		pause();
		chk({b8, il, cl, al}, {mode_bl8, mode_ilv, mode_cl, mode_al});
	endtask : setm
	task automatic t_mode;
		setm(1'b1, 1'b1, 3'h4, 3'h1);
		issue(DCB_MRS, 3'h0, 13'h0031);
		issue(DCB_NOP, 3'h0, 13'h1FFF);
		pause();
		chk(mode_bl8, 1'b1);
	endtask : t_mode
	task automatic t_order;
		logic [2:0] s, n, e;
		int b, i, j;
		for (b = 0; b < 4; b++) begin
			setm(b[1], b[0], 3'h3, 3'h0);
			for (i = 0; i < 8; i++) begin
				s = i[2:0];
				cols.delete();
				issue(DCB_RD, 3'h0, {3'h0, 7'h05, s});
				issue(DCB_NOP, 3'h0, 13'h0000);
				pause();
				chk(cols.size(), b[1] ? 8 : 4);
				for (j = 0; j < cols.size(); j++) begin
					n = j[2:0];
					e = b[0] ? s ^ n : {s[2] ^ (b[1] & n[2]), s[1:0] + n[1:0]};
					chk(cols[j], {7'h05, e});
				end
			end
		end
	endtask : t_order
	task automatic t_data;
		logic [2:0]   c;
		logic [127:0] v;
		int i;
		setm(1'b1, 1'b0, 3'h3, 3'h0);
		for (i = 0; i < 8; i++) v[16*i+:16] = 16'hA000 + i[15:0];
		wd <= v;
		issue(DCB_WR, 3'h1, 13'h0040);
		pause();
		setm(1'b0, 1'b0, 3'h3, 3'h0);
		for (i = 0; i < 8; i++) v[16*i+:16] = 16'hB000 + i[15:0];
		wd <= v;
		cols.delete();
		abk.delete();
		issue(DCB_WR, 3'h1, 13'h0040);
		pause();
		chk(cols.size(), 4);
		chk(abk[0], 4'h9);
		setm(1'b1, 1'b0, 3'h3, 3'h0);
		rdq.delete();
		issue(DCB_RD, 3'h1, 13'h0043);
		pause();
		chk(rdq.size(), 8);
		for (i = 0; i < 8; i++) begin
			c = {i[2], i[1:0] + 2'h3};
			chk(rdq[i], (c[2] ? 16'hA000 : 16'hB000) + {13'h0000, c});
		end
	endtask : t_data
	task automatic t_burst;
		int i;
		setm(1'b0, 1'b0, 3'h3, 3'h2);
		rdq.delete();
		rdt.delete();
		aps.delete();
		issue(DCB_RD, 3'h5, 13'h0404);
		issue(DCB_RD, 3'h2, 13'h0008);
		pause();
		chk(rdq.size(), 8);
		for (i = 1; i < 8; i++) chk(rdt[i] - rdt[i-1], 4);
		chk(aps.size(), 1);
		chk(aps[0], 3'h5);
		setm(1'b1, 1'b0, 3'h3, 3'h0);
		cols.delete();
		issue(DCB_RD, 3'h2, 13'h0000);
		issue(DCB_RD, 3'h2, 13'h0010);
		pause();
		chk(cols.size(), 12);
		chk(cols[4], 10'h010);
	endtask : t_burst
	task automatic meas(input dcb_cmd_t k, output int n);
		issue(k, 3'h3, 13'h0080);
		cmd_valid <= 1'b0;
		// looked at mid-cycle so the strobe is settled
		for (n = 0; n < 300; n++) begin
			@(negedge sys_clk);
			if (k == DCB_RD && (lnk.dqs_dev_en && lnk.dqs_dev) === 1'b1) break;
			if (k == DCB_WR && (lnk.dqs_ctl_en && lnk.dqs_ctl) === 1'b1) break;
		end
		if (n == 300) errors++;
		pause();
	endtask : meas
	task automatic t_lat;
		logic [2:0] cl, al;
		int i, r0, w0, r, w;
		for (i = 0; i < 4; i++) begin
			al = (i > 1) ? i[2:0] - 3'h1 : 3'h0;
			cl = (i == 1) ? 3'h4 : ((i == 3) ? 3'h5 : 3'h3);
			setm(1'b0, 1'b0, cl, al);
			meas(DCB_RD, r);
			meas(DCB_WR, w);
			if (i == 0) begin
				r0 = r;
				w0 = w;
			end
			chk(r - r0, 8 * (int'(al) + int'(cl) - 3));
			chk(w - w0, 8 * (int'(al) + int'(cl) - 3));
		end
	endtask : t_lat
	// spacing the controller enforces: early column after activate, turnaround, recovery
	task automatic t_pre;
		int t;
		setm(1'b0, 1'b0, 3'h3, 3'h0);
		issue(DCB_ACT, 3'h4, 13'h0000);
		t = cyc;
		issue(DCB_RD, 3'h4, 13'h0000);
		chk(cyc - t, 8 * 3);
		t = cyc;
		issue(DCB_WR, 3'h4, 13'h0000);
		chk(cyc - t, 8 * (2 + 2));
		t = cyc;
		issue(DCB_PRE, 3'h4, 13'h0000);
		chk(cyc - t, 8 * (2 + 2 + 3));
		pause();
	endtask : t_pre
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (60000) @(posedge sys_clk);
		errors++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = DCB_NOP;
		cmd_bank = 3'h0;
		cmd_addr = 13'h0000;
		wd = '0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		issue(DCB_ACT, 3'h0, 13'h0000);
		pause();
		t_mode();
		$display("mode test done");
		t_order();
		$display("order test done");
		t_data();
		$display("data test done");
		t_burst();
		$display("burst test done");
		t_lat();
		$display("latency test done");
		t_pre();
		$display("precharge test done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
